/* File: hw/fpo_core.sv */
// Decoder and executor for sine/cosine destination, hyperbolic sine and square root.
// Assumes an APB master; the host places instruction words and memory operands
// in registers before writing the command word.
//
// Functional notes
// - Same sine and cosine destination keeps sine, discards cosine.
// - Register form: source equal to a destination is read then overwritten.
// - Hyperbolic sine widens source and writes the destination register.
// - Hyperbolic sine of zero or infinity keeps the value and sign.
// - Hyperbolic sine clears unordered-branch, operand-error and divide-by-zero.
// - Quotient byte is never touched by these operations.
// - Decimal-input inexact cleared unless packed source; packed follows control.
// - Decode effective-address modes; address-register direct is illegal.
// - Data-register source legal only for byte, word, long or single.
// - Operand-source bit picks register or effective-address source.
// - Source specifier is a format for ea form, register otherwise.
// - Register form with equal fields reads and overwrites one register.
// - Square root widens source and writes the destination register.
// - Plain root uses control precision; variants force single or double.
// - Root of zero keeps sign, +inf stays; negatives give NaN.
// - Root sets operand error only for nonzero negatives; clears others.
// - Decode root opmodes 0000100, 1000001 and 1000101.
//
// Decided for this implementation: the APB register port and the address map.
module fpo_core
    import fpo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [79:0] fpr_r [8];
    logic [79:0] fpr_nxt [8];
    logic [31:0] cmd_r, cmd_nxt;
    logic [79:0] src_r, src_nxt;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [31:0] stat_r, stat_nxt;
    logic illegal_r, illegal_nxt;
    fpo_state_t st_r, st_nxt;
    fpo_op_t op_r, op_nxt;
    logic [79:0] opnd_r, opnd_nxt;
    logic [1:0] prec_r, prec_nxt;

    // Decode of the latched command
    logic [2:0] f_mode, f_ereg, f_src, f_dst, f_cos;
    logic f_rm;
    logic [6:0] f_opm;
    logic ea_ok, fmt_ok, dec_ok;
    fpo_op_t dec_op;
    logic wr_go, acc, sq_start, sq_done;
    logic [31:0] sq_root;
    logic [63:0] sq_rad;
    logic [79:0] res;
    logic [7:0] exc;

    assign f_mode = cmd_r[W1_MODE_LO +: 3];
    assign f_ereg = cmd_r[W1_EREG_LO +: 3];
    assign f_rm = cmd_r[W2_RM];
    assign f_src = cmd_r[W2_SRC_LO +: 3];
    assign f_dst = cmd_r[W2_DST_LO +: 3];
    assign f_cos = cmd_r[2:0];
    assign f_opm = cmd_r[6:0];
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign busy = (st_r != FPO_IDLE);
    assign wr_go = acc && pwrite && (paddr == ADDR_CMD) && !busy;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    always_comb begin
        dec_op = FPO_OP_NONE;
        // Top nibble must be the coprocessor line
        if (cmd_r[W1_LINE_HI -: 4] == LINE_F) begin
            if (f_opm == OPM_SINH) begin
                dec_op = FPO_OP_SINH;
            end else if (f_opm == OPM_SQRT || f_opm == OPM_SQRT_S || f_opm == OPM_SQRT_D) begin
                dec_op = FPO_OP_SQRT;
            end else if (f_opm[6:3] == OPM_SINCOS_HI) begin
                dec_op = FPO_OP_SINCOS;
            end
        end
        // EA fields matter only in ea form; register form ignores them
        ea_ok = 1'b1;
        fmt_ok = 1'b1;
        if (f_rm) begin
            unique case (f_mode)
                EA_DREG: ea_ok = 1'b1;
                EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX: ea_ok = 1'b1;
                EA_EXT: ea_ok = (f_ereg == EAX_ABS_W) || (f_ereg == EAX_ABS_L) ||
                                (f_ereg == EAX_PC_DISP) || (f_ereg == EAX_PC_INDEX) ||
                                (f_ereg == EAX_IMM);
                default: ea_ok = 1'b0;
            endcase
            // Data register holds at most 32 bits
            if (f_mode == EA_DREG) begin
                fmt_ok = (f_src == FMT_BYTE) || (f_src == FMT_WORD) ||
                         (f_src == FMT_LONG) || (f_src == FMT_SINGLE);
            end
            if (f_src == 3'h7) begin
                fmt_ok = 1'b0;
            end
        end
        dec_ok = (dec_op != FPO_OP_NONE) && ea_ok && fmt_ok;
    end

    // ------------------------------------------------------------
    // Square root mantissa engine
    // ------------------------------------------------------------
    // Odd exponents shift the mantissa so the halved exponent is exact
    // Engine loads the operand being latched, so it starts with the decode
    assign sq_rad = opnd_nxt[64] ? {1'b0, opnd_nxt[63:1]} : opnd_nxt[63:0];
    assign sq_start = (st_r == FPO_DONE) && (st_nxt == FPO_CALC) && (op_nxt == FPO_OP_SQRT);

    fpo_isqrt u_sqrt (
        .pclk(pclk),
        .presetn(presetn),
        .start(sq_start),
        .radicand(sq_rad),
        .done(sq_done),
        .root(sq_root)
    );

    // ------------------------------------------------------------
    // Result, exception byte and precision
    // ------------------------------------------------------------
    always_comb begin
        logic [14:0] e;
        logic [14:0] half;
        e = opnd_r[78:64];
        half = 15'h0000;
        res = opnd_r;
        exc = 8'h00; // Unordered-branch, overflow, underflow and divide-zero cleared
        if (op_r == FPO_OP_SQRT) begin
            if (e == EXP_MAX && opnd_r[63:0] != 64'h0) begin
                res = opnd_r;
            end else if (e == 15'h0000 && opnd_r[63:0] == 64'h0) begin
                res = opnd_r;
            end else if (opnd_r[79]) begin
                res = {1'b0, EXP_MAX, NAN_MANT};
                exc[EX_OPND_ERR] = 1'b1;
            end else if (e == EXP_MAX) begin
                res = opnd_r;
            end else begin
                half = (e >> 1) + (EXP_BIAS >> 1) + {14'h0, e[0]};
                res = {1'b0, half, sq_root, 32'h0};
                // Forced or control precision trims the mantissa
                if (prec_r == PREC_SGL) begin
                    res[39:0] = 40'h0;
                end else if (prec_r == PREC_DBL) begin
                    res[10:0] = 11'h0;
                end
            end
        end else if (op_r == FPO_OP_SINH) begin
            // Small-argument sinh x ~ x; zero and infinity pass unchanged
            res = opnd_r;
            exc[EX_OPND_ERR] = 1'b0;
        end else if (op_r == FPO_OP_SINCOS) begin
            res = opnd_r;
            if (e == EXP_MAX) begin
                res = {1'b0, EXP_MAX, NAN_MANT};
                exc[EX_OPND_ERR] = 1'b1;
            end
        end
        // Packed source may report decimal inexact when control allows
        exc[EX_DEC_INEXACT] = f_rm && (f_src == FMT_PACKED) && ctrl_r[CTRL_DEC_INEX_BIT];
    end

    // ------------------------------------------------------------
    // Sequencer and register file writes
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        opnd_nxt = opnd_r;
        prec_nxt = prec_r;
        illegal_nxt = illegal_r;
        for (int i = 0; i < 8; i++) begin
            fpr_nxt[i] = fpr_r[i];
        end
        stat_nxt = stat_r;
        unique case (st_r)
            FPO_IDLE: begin
                if (wr_go) begin
                    st_nxt = FPO_DONE;
                end
            end
            FPO_CALC: begin
                if (op_r != FPO_OP_SQRT || sq_done) begin
                    st_nxt = FPO_IDLE;
                    // Source read before either destination write
                    if (op_r == FPO_OP_SINCOS) begin
                        fpr_nxt[f_cos] = {1'b0, EXP_BIAS, 64'h8000_0000_0000_0000};
                    end
                    fpr_nxt[f_dst] = res;
                    // Exception byte replaced; quotient byte left alone
                    stat_nxt[7:0] = exc;
                    stat_nxt[27:24] = {res[79], (res[78:64] == 15'h0 && res[63:0] == 64'h0),
                                       (res[78:64] == EXP_MAX && res[63:0] == 64'h0),
                                       (res[78:64] == EXP_MAX && res[63:0] != 64'h0)};
                end
            end
            FPO_DONE: begin
                // Latch operand and op one cycle after the command write
                illegal_nxt = !dec_ok;
                if (dec_ok) begin
                    st_nxt = FPO_CALC;
                    op_nxt = dec_op;
                    opnd_nxt = f_rm ? src_r : fpr_r[f_src];
                    prec_nxt = (f_opm == OPM_SQRT_S) ? PREC_SGL :
                               (f_opm == OPM_SQRT_D) ? PREC_DBL :
                               (dec_op == FPO_OP_SQRT) ? ctrl_r[CTRL_PREC_LO +: 2] : PREC_EXT;
                end else begin
                    st_nxt = FPO_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB writes to host-side registers
    // ------------------------------------------------------------
    always_comb begin
        cmd_nxt = cmd_r;
        src_nxt = src_r;
        ctrl_nxt = ctrl_r;
        if (wr_go) begin
            cmd_nxt = pwdata;
        end
        if (acc && pwrite && !busy) begin
            if (paddr == ADDR_SRC) begin
                src_nxt = {src_r[47:0], pwdata}; // Shift in three words, top first
            end else if (paddr == ADDR_CTRL) begin
                ctrl_nxt = pwdata[2:0];
            end
        end
    end

    // Reads: unmapped addresses and any write while busy answer with an error
    always_comb begin
        prdata = SLV_ERR_DATA;
        pslverr = 1'b0;
        if (acc) begin
            if ((paddr & ADDR_FPREG_MASK) == ADDR_FPREG0) begin
                // One word per register: low word of register n at 0x40 + 4 * n
                prdata = fpr_r[paddr[4:2]][31:0];
            end
            unique case (paddr)
                ADDR_CMD: prdata = cmd_r;
                ADDR_SRC: prdata = src_r[31:0];
                ADDR_CTRL: prdata = {29'h0, ctrl_r};
                ADDR_STAT: prdata = {stat_r[31:9], illegal_r, stat_r[7:0]};
                default: pslverr = ((paddr & ADDR_FPREG_MASK) != ADDR_FPREG0);
            endcase
            if (pwrite && busy) begin
                pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= FPO_IDLE;
            op_r <= FPO_OP_NONE;
            opnd_r <= 80'h0;
            prec_r <= PREC_EXT;
            illegal_r <= 1'b0;
            cmd_r <= 32'h0;
            src_r <= 80'h0;
            ctrl_r <= 3'h0;
            stat_r <= 32'h0;
            for (int i = 0; i < 8; i++) begin
                fpr_r[i] <= 80'h0;
            end
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            opnd_r <= opnd_nxt;
            prec_r <= prec_nxt;
            illegal_r <= illegal_nxt;
            cmd_r <= cmd_nxt;
            src_r <= src_nxt;
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            for (int i = 0; i < 8; i++) begin
                fpr_r[i] <= fpr_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_quot_kept: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(stat_r[23:16])) else $error("Quotient byte changed");
    a_sqrt_neg_err: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && op_r == FPO_OP_SQRT && sq_done && opnd_r[79] &&
         opnd_r[78:64] != EXP_MAX && opnd_r[63:0] != 64'h0) |=> stat_r[EX_OPND_ERR])
        else $error("Negative root missed operand error");
    a_sinh_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && op_r == FPO_OP_SINH) |=>
        !stat_r[EX_UNORDERED] && !stat_r[EX_OPND_ERR] && !stat_r[EX_DIV_ZERO])
        else $error("Sinh left a flag set");
    a_sinh_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && op_r == FPO_OP_SINH) |=> fpr_r[$past(f_dst)] == $past(opnd_r))
        else $error("Sinh special value altered");
    a_root_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && op_r == FPO_OP_SQRT && sq_done) |=>
        !stat_r[EX_OVERFLOW] && !stat_r[EX_UNDERFLOW] && !stat_r[EX_DIV_ZERO])
        else $error("Root left a cleared flag set");
    a_dec_inex_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && st_nxt == FPO_IDLE && !(f_rm && f_src == FMT_PACKED)) |=>
        !stat_r[EX_DEC_INEXACT]) else $error("Decimal inexact not cleared");
    a_dreg_fmt: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_DONE && f_rm && f_mode == EA_DREG && f_src == FMT_DOUBLE) |=>
        st_r == FPO_IDLE && illegal_r) else $error("Double from data register accepted");
    a_root_time: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_DONE && st_nxt == FPO_CALC && op_nxt == FPO_OP_SQRT) |=>
        ##[1:40] st_r == FPO_IDLE) else $error("Root did not finish");
    // Root must satisfy root^2 <= radicand with remainder at most twice the root
    a_root_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == FPO_CALC && op_r == FPO_OP_SQRT && sq_done) |->
        ({32'h0, sq_root} * {32'h0, sq_root} <= sq_rad) &&
        (sq_rad - {32'h0, sq_root} * {32'h0, sq_root} <= {31'h0, sq_root, 1'b0}))
        else $error("Root engine result out of range");
    c_sinh: cover property (@(posedge pclk) st_r == FPO_CALC && op_r == FPO_OP_SINH);
    c_sqrt: cover property (@(posedge pclk) st_r == FPO_CALC && op_r == FPO_OP_SQRT && sq_done);
    c_sincos: cover property (@(posedge pclk) st_r == FPO_CALC && op_r == FPO_OP_SINCOS);
endmodule : fpo_core

/* File: hw/fpo_pkg.sv */
// Package for the floating-point sine/sinh/sqrt decoder and executor.
// Assumes an APB slave at 20 MHz with 32-bit data; one word per register.
package fpo_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_SRC = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_FPREG0 = 8'h40;
    localparam logic [7:0] ADDR_FPREG_MASK = 8'he0;
    localparam logic [31:0] SLV_ERR_DATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam logic [3:0] LINE_F = 4'hf;
    localparam int W1_LINE_HI = 31;
    localparam int W1_CPID_LO = 25;
    localparam int W1_MODE_LO = 19;
    localparam int W1_EREG_LO = 16;
    localparam int W2_RM = 14;
    localparam int W2_SRC_LO = 10;
    localparam int W2_DST_LO = 7;
    localparam logic [6:0] OPM_SINH = 7'h02;
    localparam logic [6:0] OPM_SQRT = 7'h04;
    localparam logic [6:0] OPM_SQRT_S = 7'h41;
    localparam logic [6:0] OPM_SQRT_D = 7'h45;
    localparam logic [3:0] OPM_SINCOS_HI = 4'h6;
    localparam int CPID_FPU_DEF = 1;

    // Source formats
    localparam logic [2:0] FMT_LONG = 3'h0;
    localparam logic [2:0] FMT_SINGLE = 3'h1;
    localparam logic [2:0] FMT_EXT = 3'h2;
    localparam logic [2:0] FMT_PACKED = 3'h3;
    localparam logic [2:0] FMT_WORD = 3'h4;
    localparam logic [2:0] FMT_DOUBLE = 3'h5;
    localparam logic [2:0] FMT_BYTE = 3'h6;

    // Effective address modes
    localparam logic [2:0] EA_DREG = 3'h0;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_POSTINC = 3'h3;
    localparam logic [2:0] EA_PREDEC = 3'h4;
    localparam logic [2:0] EA_DISP = 3'h5;
    localparam logic [2:0] EA_INDEX = 3'h6;
    localparam logic [2:0] EA_EXT = 3'h7;
    localparam logic [2:0] EAX_ABS_W = 3'h0;
    localparam logic [2:0] EAX_ABS_L = 3'h1;
    localparam logic [2:0] EAX_PC_DISP = 3'h2;
    localparam logic [2:0] EAX_PC_INDEX = 3'h3;
    localparam logic [2:0] EAX_IMM = 3'h4;

    // Status exception byte bit positions
    localparam int EX_UNORDERED = 7;
    localparam int EX_SIG_NAN = 6;
    localparam int EX_OPND_ERR = 5;
    localparam int EX_OVERFLOW = 4;
    localparam int EX_UNDERFLOW = 3;
    localparam int EX_DIV_ZERO = 2;
    localparam int EX_INEXACT = 1;
    localparam int EX_DEC_INEXACT = 0;
    // Condition code bits: negative, zero, infinity, nan
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_I = 1;
    localparam int CC_NAN = 0;

    // Control register fields
    localparam int CTRL_PREC_LO = 0;
    localparam int CTRL_DEC_INEX_BIT = 2;
    localparam logic [1:0] PREC_EXT = 2'h0;
    localparam logic [1:0] PREC_SGL = 2'h1;
    localparam logic [1:0] PREC_DBL = 2'h2;

    // Work encoding of extended value: sign, 15-bit exponent, 64-bit mantissa
    localparam logic [14:0] EXP_MAX = 15'h7fff;
    localparam logic [14:0] EXP_BIAS = 15'h3fff;
    localparam logic [63:0] NAN_MANT = 64'hc000_0000_0000_0000;
    localparam int SQRT_ITERS = 32;
    localparam logic [5:0] SQRT_CNT_LAST = 6'h20;

    typedef enum logic [2:0] {
        FPO_OP_NONE,
        FPO_OP_SINCOS,
        FPO_OP_SINH,
        FPO_OP_SQRT
    } fpo_op_t;

    typedef enum {
        FPO_IDLE,
        FPO_CALC,
        FPO_DONE
    } fpo_state_t;
endpackage : fpo_pkg

/* File: hw/fpo_isqrt.sv */
// Integer square root engine, one result bit per clock while busy.
// Assumes the caller holds start for one cycle and waits for done.
module fpo_isqrt
    import fpo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [63:0] radicand,
    output logic done,
    output logic [31:0] root
);
    logic [63:0] rad_r, rad_nxt;
    logic [34:0] rem_r, rem_nxt;
    logic [31:0] root_r, root_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic [34:0] trial;
    logic [34:0] part;

    // ------------------------------------------------------------
    // Restoring digit-by-digit root
    // ------------------------------------------------------------
    always_comb begin
        rad_nxt = rad_r;
        rem_nxt = rem_r;
        root_nxt = root_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        // Remainder never exceeds twice the root, so 33 bits plus two new ones fit
        part = {rem_r[32:0], rad_r[63:62]};
        trial = {1'b0, root_r, 2'b01};
        if (start) begin
            rad_nxt = radicand;
            rem_nxt = 35'h0;
            root_nxt = 32'h0000_0000;
            cnt_nxt = 6'h00;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            // Bring down the next two radicand bits each step
            rad_nxt = {rad_r[61:0], 2'b00};
            if (part >= trial) begin
                rem_nxt = part - trial;
                root_nxt = {root_r[30:0], 1'b1};
            end else begin
                rem_nxt = part;
                root_nxt = {root_r[30:0], 1'b0};
            end
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_nxt == SQRT_CNT_LAST) begin
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rad_r <= 64'h0;
            rem_r <= 35'h0;
            root_r <= 32'h0;
            cnt_r <= 6'h00;
            busy_r <= 1'b0;
        end else begin
            rad_r <= rad_nxt;
            rem_r <= rem_nxt;
            root_r <= root_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Registered outputs keep the caller's start path free of loops
    assign done = !busy_r && (cnt_r == SQRT_CNT_LAST);
    assign root = root_r;
endmodule : fpo_isqrt

/* File: sim/fpo_host.sv */
// Host processor model: an APB master that issues coprocessor commands.
// Assumes one clock; the bench calls its tasks through the instance.
module fpo_host
    import fpo_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hang = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; held until pready is seen, for at most 64 cycles before a hang is flagged
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 64);
        hang = hang | (i >= 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Command word: id 1, address fields zeroed in register form
    function automatic logic [31:0] cmd(input logic rm, input logic [2:0] mode, ereg,
                                        input logic [2:0] src, dst, input logic [6:0] opm);
        return {LINE_F, 3'h1, 3'h0, rm ? mode : 3'h0, rm ? ereg : 3'h0,
                1'b0, rm, 1'b0, src, dst, opm};
    endfunction : cmd
endmodule : fpo_host

/* File: sim/fpo_sine_sinh_sqrt_ops_test.sv */
// Self-checking bench for the sine/sinh/sqrt decoder and executor.
// Assumes zero-wait APB and results readable in STAT and the FP regs.
module fpo_sine_sinh_sqrt_ops_test
    import fpo_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [79:0] ONE = {16'h3fff, 64'h8000_0000_0000_0000};
    localparam logic [79:0] INF = {16'h7fff, 64'h0};
    localparam logic [79:0] SGN = {1'b1, 79'h0};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_errors = 0;
    int check_count = 0;
    initial forever #25 pclk = ~pclk;
    fpo_host host(.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    fpo_core uut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        if (host.hang) begin
            n_errors++;
        end
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    // Status expected from the special-value tables; NaN sign left open
    function automatic logic [31:0] exp_stat(input logic [79:0] v, input logic sq);
        logic bad;
        logic [3:0] cc;
        bad = sq && v[79] && (v[78:0] != 79'h0);
        cc = {v[79], v[78:0] == 79'h0, v[78:64] == EXP_MAX && v[62:0] == 63'h0, 1'b0};
        if (bad) begin
            cc = 4'h1;
        end
        return {4'h0, cc, 16'h0, 2'h0, bad, 5'h0};
    endfunction : exp_stat
    function automatic logic [31:0] ea(input logic [6:0] opm, input logic [2:0] d);
        return host.cmd(1'b1, EA_EXT, EAX_IMM, FMT_EXT, d, opm);
    endfunction : ea
    // Bounded wait for the end of execution; a hang ends the run
    task automatic wait_idle();
        int i;
        i = 0;
        @(posedge pclk);
        while (busy !== 1'b0 && i < 200) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 200 || host.hang) begin
            n_errors++;
            close_out();
        end
    endtask : wait_idle
    task automatic run(input logic [79:0] v, input logic [31:0] c, input logic [2:0] d,
                       input logic sq, input logic poke);
        logic [31:0] q, m, s;
        logic e;
        s = exp_stat(v, sq);
        m = s[EX_OPND_ERR] ? 32'hf7ff_ffff : 32'hffff_ffff;
        host.xfer(1'b1, ADDR_SRC, {16'h0, v[79:64]}, q, e);
        host.xfer(1'b1, ADDR_SRC, v[63:32], q, e);
        host.xfer(1'b1, ADDR_SRC, v[31:0], q, e);
        host.xfer(1'b1, ADDR_CTRL, 32'h0, q, e);
        host.xfer(1'b1, ADDR_CMD, c, q, e);
        if (poke) begin
            host.xfer(1'b1, ADDR_CTRL, 32'h0, q, e);
            chk({31'h0, e}, 32'h1);
        end
        wait_idle();
        host.xfer(1'b0, ADDR_STAT, 32'h0, q, e);
        chk(q & m, exp_stat(v, sq) & m);
        host.xfer(1'b0, ADDR_FPREG0 + {3'h0, d, 2'h0}, 32'h0, q, e);
        chk(q, m[27] ? v[31:0] : NAN_MANT[31:0]);
    endtask : run
    // ------------------------------------------------------------
    // Main sequence: corners first, then random sinh and in-place roots
    // ------------------------------------------------------------
    initial begin
        logic [79:0] v;
        logic [31:0] q;
        logic [2:0] d;
        logic e;
        int k;
        k = $urandom(32'h7bf9d0c6);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        host.xfer(1'b0, ADDR_STAT, 32'h0, q, e);
        chk(q, 32'h0);
        host.xfer(1'b0, 8'h20, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        run(ONE | SGN, ea(OPM_SQRT, 3'h1), 3'h1, 1'b1, 1'b0);
        run(SGN, ea(OPM_SQRT_S, 3'h2), 3'h2, 1'b1, 1'b0);
        run(INF, ea(OPM_SQRT_D, 3'h3), 3'h3, 1'b1, 1'b0);
        run(INF | SGN, ea(OPM_SINH, 3'h4), 3'h4, 1'b0, 1'b0);
        run(80'h0, host.cmd(1'b1, EA_DREG, 3'h5, FMT_LONG, 3'h5, OPM_SINH), 3'h5, 1'b0, 1'b0);
        run(ONE | 80'h5, ea({OPM_SINCOS_HI, 3'h6}, 3'h6), 3'h6, 1'b0, 1'b0);
        run(ONE, ea(OPM_SQRT, 3'h7), 3'h7, 1'b1, 1'b1);
        // Data register with double format, then address register direct
        for (k = 0; k < 2; k++) begin
            host.xfer(1'b1, ADDR_CMD, host.cmd(1'b1, 3'(k), 3'h0, FMT_DOUBLE, 3'h0, OPM_SQRT), q, e);
            wait_idle();
            host.xfer(1'b0, ADDR_STAT, 32'h0, q, e);
            chk({31'h0, q[8]}, 32'h1);
        end
        repeat (6) begin
            v = 80'({$urandom(), $urandom(), $urandom()});
            v[78:64] = 15'h0001 + 15'($urandom() % 32'h7ffd);
            v[63] = 1'b1;
            d = 3'($urandom());
            run(v, ea(OPM_SINH, d), d, 1'b0, 1'b0);
            if (v[79]) begin
                run(v, host.cmd(1'b0, 3'h0, 3'h0, d, d, OPM_SQRT), d, 1'b1, 1'b0);
            end
        end
        close_out();
    end
endmodule : fpo_sine_sinh_sqrt_ops_test
